// file: shared/gpwm_defines.svh
`ifndef GPWM_DEFINES_SVH
`define GPWM_DEFINES_SVH

// packet layout
`define GPWM_SHIFT_W      32
`define GPWM_LATCH_W      24
`define GPWM_LEVEL_W      8
`define GPWM_CMD_LSB      24
`define GPWM_CH0_LSB      0
`define GPWM_CH1_LSB      8
`define GPWM_CH2_LSB      16
`define GPWM_WRITE_CMD    8'h3A

// reset values
`define GPWM_SHIFT_RST    32'h0000_0000
`define GPWM_LATCH_RST    24'h00_0000

// counter reaches the largest turn-off count (1902)
`define GPWM_CNT_W        11

// gamma segments: start level of the x4 and x8 slopes
`define GPWM_SEG_X4_START 8'h08
`define GPWM_SEG_X8_START 8'h20
// last on-count offsets: 2v-1, 4v-15, 8v-139
`define GPWM_SEG_X2_OFS   11'h001
`define GPWM_SEG_X4_OFS   11'h00F
`define GPWM_SEG_X8_OFS   11'h08B

`endif

// file: shared/gpwm_pkg.sv
package gpwm_pkg;
   typedef logic [7:0]  gpwm_level_t;
   typedef logic [10:0] gpwm_count_t;
   typedef logic [31:0] gpwm_shift_t;
   typedef logic [23:0] gpwm_latch_t;
endpackage

// file: logic/gpwm_gamma.sv
`timescale 1ns/10ps
`include "gpwm_defines.svh"

module gpwm_gamma (
   input  wire gpwm_pkg::gpwm_level_t level_i,
   output gpwm_pkg::gpwm_count_t      last_on_o
);
   gpwm_pkg::gpwm_count_t lvl_w;

   assign lvl_w = {3'h0, level_i};

   // last count at which the channel is still on; level 0 is gated off elsewhere
   always_comb begin
      if (level_i == 8'h00) begin
         last_on_o = 11'h000;
      end else if (level_i < `GPWM_SEG_X4_START) begin
         last_on_o = (lvl_w << 1) - `GPWM_SEG_X2_OFS;
      end else if (level_i < `GPWM_SEG_X8_START) begin
         last_on_o = (lvl_w << 2) - `GPWM_SEG_X4_OFS;
      end else begin
         last_on_o = (lvl_w << 3) - `GPWM_SEG_X8_OFS;
      end
   end
endmodule

// file: logic/gpwm_core.sv
`timescale 1ns/10ps
`include "gpwm_defines.svh"

// Overview of operation
// - each of three channels holds an eight-bit level, 256 steps
// - brightness counter advances once per reference clock rising edge
// - at count one all nonzero channels switch on; zero channels stay off
// - channel stays on while count is at or below its threshold
// - a latch write clears the counter and forces every output off
// - counting restarts on the next reference edge with the new levels
// - threshold follows a piecewise gamma curve: 1->1, 8->17, 255->1901
// - outputs stay off after power-up until nonzero levels are latched
// - a 32-bit shift register feeds a separate 24-bit level latch
// - latch pulse copies low 24 bits only when top byte is 3Ah
// - bits 0-7 channel zero, 8-15 channel one, 16-23 channel two
// - latch pulse comes in on its own input, latch_update_sequence_i
module gpwm_core #(
   parameter int CNT_W = `GPWM_CNT_W
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        brightness_ref_clock_i,
   input  wire logic        serial_bit_i,
   input  wire logic        serial_bit_valid_i,
   input  wire logic        latch_update_sequence_i,
   output logic [2:0]       led_sink_output_o,
   output logic [7:0]       channel_zero_level_o,
   output logic [7:0]       channel_one_level_o,
   output logic [7:0]       channel_two_level_o,
   output logic [7:0]       packet_command_byte_o
);
   gpwm_pkg::gpwm_shift_t shift_ff;
   gpwm_pkg::gpwm_shift_t nxt_shift;
   gpwm_pkg::gpwm_latch_t latch_ff;
   gpwm_pkg::gpwm_latch_t nxt_latch;
   logic [CNT_W-1:0]      cnt_ff;
   logic [CNT_W-1:0]      nxt_cnt;
   logic [2:0]            led_ff;
   logic [2:0]            nxt_led;
   logic                  ref_prev_ff;
   logic                  nxt_ref_prev;
   logic                  ref_rise;
   logic                  write_ok;
   gpwm_pkg::gpwm_level_t lvl      [3];
   gpwm_pkg::gpwm_level_t nxt_lvl  [3];
   gpwm_pkg::gpwm_count_t last_on  [3];

   assign ref_rise = brightness_ref_clock_i & ~ref_prev_ff;
   assign write_ok = latch_update_sequence_i
                     & (shift_ff[`GPWM_SHIFT_W-1:`GPWM_CMD_LSB] == `GPWM_WRITE_CMD);

   assign lvl[0]     = latch_ff[`GPWM_CH0_LSB +: `GPWM_LEVEL_W];
   assign lvl[1]     = latch_ff[`GPWM_CH1_LSB +: `GPWM_LEVEL_W];
   assign lvl[2]     = latch_ff[`GPWM_CH2_LSB +: `GPWM_LEVEL_W];
   assign nxt_lvl[0] = nxt_latch[`GPWM_CH0_LSB +: `GPWM_LEVEL_W];
   assign nxt_lvl[1] = nxt_latch[`GPWM_CH1_LSB +: `GPWM_LEVEL_W];
   assign nxt_lvl[2] = nxt_latch[`GPWM_CH2_LSB +: `GPWM_LEVEL_W];

   // thresholds follow the new levels so the first period after a write is right
   for (genvar g = 0; g < 3; g++) begin : g_gamma
      gpwm_gamma u_gamma (
         .level_i   (nxt_lvl[g]),
         .last_on_o (last_on[g])
      );
   end

   // shift register and level latch
   always_comb begin
      nxt_shift = shift_ff;
      nxt_latch = latch_ff;
      if (serial_bit_valid_i) begin
         nxt_shift = {shift_ff[`GPWM_SHIFT_W-2:0], serial_bit_i};
      end
      if (write_ok) begin
         nxt_latch = shift_ff[`GPWM_LATCH_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         shift_ff <= `GPWM_SHIFT_RST;
         latch_ff <= `GPWM_LATCH_RST;
      end else begin
         shift_ff <= nxt_shift;
         latch_ff <= nxt_latch;
      end
   end

   // brightness counter; the reference clock is sampled, so it must stay at or below clk_i/2
   always_comb begin
      nxt_ref_prev = brightness_ref_clock_i;
      nxt_cnt      = cnt_ff;
      if (write_ok) begin
         nxt_cnt = '0;
      end else if (ref_rise) begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   // outputs as a level of the next count: on in 1..threshold, never for level 0
   always_comb begin
      nxt_led = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (!write_ok && nxt_lvl[i] != 8'h00 && nxt_cnt != '0
             && gpwm_pkg::gpwm_count_t'(nxt_cnt) <= last_on[i]) begin
            nxt_led[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_prev_ff <= 1'b0;
         cnt_ff      <= '0;
         led_ff      <= 3'h0;
      end else begin
         ref_prev_ff <= nxt_ref_prev;
         cnt_ff      <= nxt_cnt;
         led_ff      <= nxt_led;
      end
   end

   assign led_sink_output_o     = led_ff;
   assign channel_zero_level_o  = lvl[0];
   assign channel_one_level_o   = lvl[1];
   assign channel_two_level_o   = lvl[2];
   assign packet_command_byte_o = shift_ff[`GPWM_SHIFT_W-1:`GPWM_CMD_LSB];

   // checks
   gpwm_pkg::gpwm_count_t last_on_ff [3];

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_on_ff <= '{default: 11'h000};
      end else begin
         last_on_ff <= last_on;
      end
   end

   property p_zero_off;
      @(posedge clk_i) disable iff (!nrst_i)
      (lvl[0] == 8'h00) |-> !led_ff[0];
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero level channel lit");

   property p_on_at_one;
      @(posedge clk_i) disable iff (!nrst_i)
      (cnt_ff == CNT_W'(1) && lvl[1] != 8'h00) |-> led_ff[1];
   endproperty
   a_on_at_one: assert property (p_on_at_one) else $error("channel dark at count one");

   property p_off_above;
      @(posedge clk_i) disable iff (!nrst_i)
      (gpwm_pkg::gpwm_count_t'(cnt_ff) > last_on_ff[2]) |-> !led_ff[2];
   endproperty
   a_off_above: assert property (p_off_above) else $error("channel lit above threshold");

   property p_write_clears;
      @(posedge clk_i) disable iff (!nrst_i)
      write_ok |=> (cnt_ff == 0 && led_ff == 3'h0 && latch_ff == $past(shift_ff[23:0]));
   endproperty
   a_write_clears: assert property (p_write_clears) else $error("latch write not applied");

   property p_bad_cmd;
      @(posedge clk_i) disable iff (!nrst_i)
      (latch_update_sequence_i && !write_ok) |=> $stable(latch_ff);
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("latch took bad command");

   property p_count_step;
      @(posedge clk_i) disable iff (!nrst_i)
      (ref_rise && !write_ok) |=> cnt_ff == CNT_W'($past(cnt_ff) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter missed a step");

   property p_count_hold;
      @(posedge clk_i) disable iff (!nrst_i)
      (!ref_rise && !write_ok) |=> $stable(cnt_ff);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("counter moved without edge");

   property p_shift_msb;
      @(posedge clk_i) disable iff (!nrst_i)
      serial_bit_valid_i |=> shift_ff == {$past(shift_ff[30:0]), $past(serial_bit_i)};
   endproperty
   a_shift_msb: assert property (p_shift_msb) else $error("shift register wrong");

   property p_gamma_top;
      @(posedge clk_i) disable iff (!nrst_i)
      (lvl[0] == 8'hFF) |-> last_on_ff[0] == 11'h76D;
   endproperty
   a_gamma_top: assert property (p_gamma_top) else $error("gamma top point wrong");

   property p_gamma_knee;
      @(posedge clk_i) disable iff (!nrst_i)
      (lvl[1] == 8'h08) |-> last_on_ff[1] == 11'h011;
   endproperty
   a_gamma_knee: assert property (p_gamma_knee) else $error("gamma knee point wrong");

   property p_dark_blank;
      @(posedge clk_i) disable iff (!nrst_i)
      (latch_ff == `GPWM_LATCH_RST) |-> (led_ff == 3'h0);
   endproperty
   a_dark_blank: assert property (p_dark_blank) else $error("output lit with no levels");

   property p_wrap;
      @(posedge clk_i) disable iff (!nrst_i)
      (ref_rise && !write_ok && cnt_ff == '1) |=> (cnt_ff == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_ch_map;
      @(posedge clk_i) disable iff (!nrst_i)
      write_ok |=> (channel_zero_level_o == $past(shift_ff[7:0])
                    && channel_one_level_o == $past(shift_ff[15:8])
                    && channel_two_level_o == $past(shift_ff[23:16]));
   endproperty
   a_ch_map: assert property (p_ch_map) else $error("channel field misplaced");

   c_write:  cover property (@(posedge clk_i) disable iff (!nrst_i) write_ok);
   c_bad:    cover property (@(posedge clk_i) disable iff (!nrst_i)
                             latch_update_sequence_i && !write_ok);
   c_turnon: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(led_ff[0]));
   c_wrap:   cover property (@(posedge clk_i) disable iff (!nrst_i)
                             ref_rise && cnt_ff == '1);
endmodule

// file: dv/gpwm_ctrl_model.sv
`timescale 1ns/10ps
// serial controller: msb first, back to back or with gaps, then latch pulse
module gpwm_ctrl_model (
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic        slow_i,
   input  wire logic [31:0] pkt_i,
   output logic             bit_o,
   output logic             valid_o,
   output logic             latch_o
);
   initial begin
      bit_o = 1'b0;
      valid_o = 1'b0;
      latch_o = 1'b0;
      forever begin
         @(negedge clk_i);
         if (go_i) begin
            for (int i = 31; i >= 0; i--) begin
               bit_o = pkt_i[i];
               valid_o = 1'b1;
               @(negedge clk_i);
               if (slow_i) begin
                  valid_o = 1'b0;
                  bit_o = ~bit_o;
                  @(negedge clk_i);
               end
            end
            valid_o = 1'b0;
            latch_o = 1'b1;
            @(negedge clk_i);
            latch_o = 1'b0;
         end else begin
            // idle line keeps toggling so a stale bit is never mistaken for data
            bit_o = ~bit_o;
         end
      end
   end
endmodule

// file: dv/gamma_pwm_latch_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin errors++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module gamma_pwm_latch_tb;
   logic        clk_i;
   logic        nrst_i;
   logic        ref_clk;
   logic        sbit;
   logic        sval;
   logic        slat;
   logic        go;
   logic        slow;
   logic [31:0] pkt;
   logic [2:0]  led;
   logic [7:0]  l0;
   logic [7:0]  l1;
   logic [7:0]  l2;
   logic [7:0]  cmd;
   logic [23:0] lv;
   int          cnt;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;

   gpwm_ctrl_model ctl_u (.clk_i(clk_i), .go_i(go), .slow_i(slow), .pkt_i(pkt),
      .bit_o(sbit), .valid_o(sval), .latch_o(slat));
   gpwm_core dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .brightness_ref_clock_i(ref_clk),
      .serial_bit_i(sbit), .serial_bit_valid_i(sval), .latch_update_sequence_i(slat),
      .led_sink_output_o(led), .channel_zero_level_o(l0), .channel_one_level_o(l1),
      .channel_two_level_o(l2), .packet_command_byte_o(cmd));

   function automatic int t_of(input logic [7:0] v);
      if (v < 8) return 2 * v - 1;
      if (v < 32) return 4 * v - 15;
      return 8 * v - 139;
   endfunction

   task automatic stop_test();
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one reference edge every two clocks, output checked once it has landed
   task automatic pwm(input int n);
      logic [2:0] e;
      for (int k = 0; k < n; k++) begin
         ref_clk <= 1'b1;
         @(negedge clk_i);
         ref_clk <= 1'b0;
         cnt = (cnt + 1) % 2048;
         for (int c = 0; c < 3; c++) begin
            e[c] = cnt != 0 && lv[c*8+:8] != 0 && cnt <= t_of(lv[c*8+:8]);
         end
         `CHK("led", e, led)
         @(negedge clk_i);
      end
   endtask

   task automatic send(input logic [31:0] p, input logic s);
      logic [2:0] old;
      old = led;
      pkt <= p;
      slow <= s;
      go <= 1'b1;
      @(negedge clk_i);
      go <= 1'b0;
      // model needs 32 or 64 bit slots plus the latch slot
      repeat (s ? 65 : 33) @(negedge clk_i);
      `CHK("cmd", p[31:24], cmd)
      if (p[31:24] == 8'h3A) begin
         lv = p[23:0];
         cnt = 0;
         old = 3'h0;
      end
      `CHK("levels", lv, {l2, l1, l0})
      `CHK("led", old, led)
   endtask

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         stop_test();
      end
   end

   initial begin
      logic [31:0] p;
      nrst_i = 1'b0;
      ref_clk = 1'b0;
      go = 1'b0;
      slow = 1'b0;
      pkt = 32'h0000_0000;
      lv = 24'h00_0000;
      cnt = 0;
      void'($urandom(32'h78D8));
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      `CHK("outs", 35'h0_0000_0000, {cmd, l2, l1, l0, led})
      pwm(5);
      send(32'h3AFF_0801, 1'b0);
      pwm(2050);
      send(32'h3A00_2000, 1'b1);
      pwm(2050);
      for (int k = 0; k < 4; k++) begin
         p = $urandom;
         if (k[0]) p[31:24] = 8'h3A;
         else if (p[31:24] == 8'h3A) p[31:24] = 8'h3B;
         send(p, k[1]);
         pwm(2050);
      end
      stop_test();
   end
endmodule
